// file: hdl/swhd_pkg.sv
package swhd_pkg;

  // ----------------------------------------------------------------
  // Status word layout
  // ----------------------------------------------------------------
  localparam int unsigned STAT_WIDTH = 16;
  localparam int unsigned BIT_PARAM_WRITE = 15;
  localparam int unsigned BIT_LINK_READY = 12;
  localparam int unsigned BIT_FAULT_FLAG = 11;
  localparam int unsigned BIT_SLOWING_DOWN = 10;
  localparam int unsigned BIT_SPEEDING_UP = 9;
  localparam int unsigned BIT_CURRENT_LIMITING = 8;
  localparam int unsigned BIT_VOLTAGE_LIMITING = 7;
  localparam int unsigned BIT_BUS_ABOVE_UV = 5;
  localparam int unsigned BIT_OUTPUT_SHUT_OFF = 3;
  localparam int unsigned BIT_DC_BRAKING = 2;
  localparam int unsigned BIT_BACKWARD_RUN = 1;
  localparam int unsigned BIT_FORWARD_RUN = 0;
  localparam logic [15:0] STAT_ZERO_MASK = 16'h6050;
  localparam logic [15:0] STAT_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Menus, items and keys
  // ----------------------------------------------------------------
  localparam logic [1:0] MENU_SCOPE_FULL = 2'h2;
  localparam logic [2:0] MENU_FIRST = 3'h1;
  localparam logic [2:0] MENU_LAST = 3'h5;
  localparam logic [2:0] MENU_IO_CHECK = 3'h4;
  localparam logic [2:0] MENU_RESET = 3'h1;
  localparam logic [2:0] ITEM_CTRL = 3'h0;
  localparam logic [2:0] ITEM_COMM = 3'h1;
  localparam logic [2:0] ITEM_VOLT = 3'h2;
  localparam logic [2:0] ITEM_CURR = 3'h3;
  localparam logic [2:0] ITEM_METER = 3'h4;
  localparam logic [2:0] ITEM_RESET = 3'h0;
  localparam int unsigned KEY_COUNT = 5;
  localparam int unsigned KEY_PROG = 0;
  localparam int unsigned KEY_UP = 1;
  localparam int unsigned KEY_DOWN = 2;
  localparam int unsigned KEY_FUNC = 3;
  localparam int unsigned KEY_RESET = 4;

  // ----------------------------------------------------------------
  // Segment view layout, bit 0 = a ... bit 6 = g, bit 7 = dp
  // ----------------------------------------------------------------
  localparam logic [7:0] SEG_BLANK = 8'h00;
  localparam logic [7:0] SEG_UNDERSCORE = 8'h08;
  localparam logic [7:0] SEG_DASH = 8'h40;
  localparam int unsigned TERM_IN_LSB = 0;
  localparam int unsigned TERM_COMM_LSB = 13;
  localparam int unsigned TERM_OUT_DIGITAL = 0;
  localparam int unsigned TERM_OUT_RELAY = 8;

  typedef enum logic [3:0] {
    SWHD_MODE_RUN = 4'b0001,
    SWHD_MODE_MENU = 4'b0010,
    SWHD_MODE_LIST = 4'b0100,
    SWHD_MODE_DATA = 4'b1000
  } swhd_mode_t;

endpackage : swhd_pkg

// file: hdl/swhd_glyph.sv
module swhd_glyph (
  // Nibble in
  input wire logic [3:0] nibble,
  // Segments out, bit 0 = a ... bit 6 = g
  output logic [6:0] segs
);

  // ----------------------------------------------------------------
  // Hex glyphs
  // ----------------------------------------------------------------
  always_comb begin
    unique case (nibble)
      4'h0: segs = 7'h3f;
      4'h1: segs = 7'h06;
      4'h2: segs = 7'h5b;
      4'h3: segs = 7'h4f;
      4'h4: segs = 7'h66;
      4'h5: segs = 7'h6d;
      4'h6: segs = 7'h7d;
      4'h7: segs = 7'h07;
      4'h8: segs = 7'h7f;
      4'h9: segs = 7'h6f;
      4'ha: segs = 7'h77;
      // Lower case so b and d differ from 8 and 0
      4'hb: segs = 7'h7c;
      4'hc: segs = 7'h39;
      4'hd: segs = 7'h5e;
      4'he: segs = 7'h79;
      4'hf: segs = 7'h71;
    endcase
  end

endmodule : swhd_glyph

// file: hdl/swhd_display.sv
// Functional notes
// - Bit 15 set while parameters written
// - Bit 12 set when link ready
// - Bit 11 set on fault alarm
// - Bit 8 set while current limiting
// - Bit 7 set while voltage limiting
// - Bit 5 set above undervoltage level
// - Bit 3 set when output shut off
// - Bit 2 set during DC braking
// - Bit 1 set running backward
// - Bit 0 set running forward
// - Four hex digits, bits 15-12 leftmost
// - Hex glyphs, b and d lower case
// - Start running; program key opens menu
// - Item 0 shows control terminal states
// - Item 1 shows link-commanded terminal states
// - Up/down toggle segment or hex view
// - Item 2 shows voltage input volts
// - Item 3 shows current input milliamperes
// - Item 4 shows meter output volts
// - Reset key: data to list, list to menu
module swhd_display (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Drive conditions, core_clk domain
  input wire logic paramWriteBusy,
  input wire logic linkReady,
  input wire logic faultFlag,
  input wire logic slowingDown,
  input wire logic speedingUp,
  input wire logic currentLimiting,
  input wire logic voltageLimiting,
  input wire logic busAboveUndervoltage,
  input wire logic outputShutOff,
  input wire logic dcBraking,
  input wire logic backwardRun,
  input wire logic forwardRun,
  // Configuration
  input wire logic [1:0] menuScopeCode,
  // Keypad pins, asynchronous, high while pressed
  input wire logic keyProg,
  input wire logic keyUp,
  input wire logic keyDown,
  input wire logic keyFunc,
  input wire logic keyReset,
  // Terminal data, display coded
  input wire logic [15:0] terminalInputs,
  input wire logic [15:0] linkTerminalInputs,
  input wire logic [15:0] terminalOutputs,
  input wire logic [15:0] voltageInputValue,
  input wire logic [15:0] currentInputValue,
  input wire logic [15:0] meterOutputValue,
  // Status and monitor
  output logic [15:0] statusWord,
  output logic [7:0] ledDigit4,
  output logic [7:0] ledDigit3,
  output logic [7:0] ledDigit2,
  output logic [7:0] ledDigit1,
  output logic progMode,
  output logic hexView
);

  typedef struct packed {
    swhd_pkg::swhd_mode_t mode;
    logic [2:0] menuSel;
    logic [2:0] itemSel;
    logic hexView;
    logic [swhd_pkg::KEY_COUNT-1:0] keySync1;
    logic [swhd_pkg::KEY_COUNT-1:0] keySync2;
    logic [swhd_pkg::KEY_COUNT-1:0] keyPrev;
    logic [15:0] statusWord;
    logic [31:0] segments;
  } swhd_state_t;

  swhd_state_t state_reg;
  swhd_state_t state_next;
  logic [swhd_pkg::KEY_COUNT-1:0] keyRaw;
  logic [swhd_pkg::KEY_COUNT-1:0] press;
  logic [15:0] dispWord;
  logic [31:0] dispSeg;
  logic [15:0] dataWord;
  logic [6:0] hexSeg [4];
  logic segView;

  // ----------------------------------------------------------------
  // Keypad
  // ----------------------------------------------------------------
  assign keyRaw = {keyReset, keyFunc, keyDown, keyUp, keyProg};
  // No debounce: keypad front end is assumed to deliver clean levels
  assign press = state_reg.keySync2 & ~state_reg.keyPrev;

  // ----------------------------------------------------------------
  // Glyphs
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 4; i++) begin : g_glyph
    swhd_glyph u_glyph (
      .nibble(dispWord[4*i +: 4]),
      .segs(hexSeg[i])
    );
  end

  // ----------------------------------------------------------------
  // Display content
  // ----------------------------------------------------------------
  always_comb begin
    dataWord = terminalInputs;
    segView = 1'b0;
    dispWord = state_reg.statusWord;
    dispSeg = {1'b0, hexSeg[3], 1'b0, hexSeg[2], 1'b0, hexSeg[1], 1'b0, hexSeg[0]};
    unique case (state_reg.itemSel)
      swhd_pkg::ITEM_CTRL: dataWord = terminalInputs;
      swhd_pkg::ITEM_COMM: dataWord = linkTerminalInputs;
      swhd_pkg::ITEM_VOLT: dataWord = voltageInputValue;
      swhd_pkg::ITEM_CURR: dataWord = currentInputValue;
      swhd_pkg::ITEM_METER: dataWord = meterOutputValue;
      default: dataWord = 16'h0000;
    endcase
    unique case (state_reg.mode)
      swhd_pkg::SWHD_MODE_RUN: begin
        dispWord = state_reg.statusWord;
      end
      swhd_pkg::SWHD_MODE_MENU: begin
        dispWord = {13'h0000, state_reg.menuSel};
        dispSeg = {swhd_pkg::SEG_BLANK, swhd_pkg::SEG_BLANK, swhd_pkg::SEG_BLANK, 1'b0, hexSeg[0]};
      end
      swhd_pkg::SWHD_MODE_LIST: begin
        dispWord = {1'b0, swhd_pkg::MENU_IO_CHECK, 4'h0, 4'h0, 1'b0, state_reg.itemSel};
        dispSeg = {1'b0, hexSeg[3], swhd_pkg::SEG_UNDERSCORE, 1'b0, hexSeg[1], 1'b0, hexSeg[0]};
      end
      swhd_pkg::SWHD_MODE_DATA: begin
        dispWord = dataWord;
        segView = !state_reg.hexView && (state_reg.itemSel <= swhd_pkg::ITEM_COMM);
        if (segView) begin
          dispSeg = {7'h00, terminalOutputs[swhd_pkg::TERM_OUT_RELAY],
                     7'h00, terminalOutputs[swhd_pkg::TERM_OUT_DIGITAL],
                     dataWord[swhd_pkg::TERM_COMM_LSB +: 3], 5'h00,
                     3'h0, dataWord[swhd_pkg::TERM_IN_LSB +: 5]};
          // All terminals off shows a row of dashes
          if (dispSeg == 32'h00000000) begin
            dispSeg = {4{swhd_pkg::SEG_DASH}};
          end
        end
      end
      default: begin
        dispSeg = {4{swhd_pkg::SEG_BLANK}};
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.keySync1 = keyRaw;
    state_next.keySync2 = state_reg.keySync1;
    state_next.keyPrev = state_reg.keySync2;
    state_next.segments = dispSeg;
    state_next.statusWord = 16'h0000;
    state_next.statusWord[swhd_pkg::BIT_PARAM_WRITE] = paramWriteBusy;
    state_next.statusWord[swhd_pkg::BIT_LINK_READY] = linkReady;
    state_next.statusWord[swhd_pkg::BIT_FAULT_FLAG] = faultFlag;
    state_next.statusWord[swhd_pkg::BIT_SLOWING_DOWN] = slowingDown;
    state_next.statusWord[swhd_pkg::BIT_SPEEDING_UP] = speedingUp;
    state_next.statusWord[swhd_pkg::BIT_CURRENT_LIMITING] = currentLimiting;
    state_next.statusWord[swhd_pkg::BIT_VOLTAGE_LIMITING] = voltageLimiting;
    state_next.statusWord[swhd_pkg::BIT_BUS_ABOVE_UV] = busAboveUndervoltage;
    state_next.statusWord[swhd_pkg::BIT_OUTPUT_SHUT_OFF] = outputShutOff;
    state_next.statusWord[swhd_pkg::BIT_DC_BRAKING] = dcBraking;
    state_next.statusWord[swhd_pkg::BIT_BACKWARD_RUN] = backwardRun;
    state_next.statusWord[swhd_pkg::BIT_FORWARD_RUN] = forwardRun;
    state_next.statusWord = state_next.statusWord & ~swhd_pkg::STAT_ZERO_MASK;

    // Program key wins over any other key in the same cycle
    unique case (state_reg.mode)
      swhd_pkg::SWHD_MODE_RUN: begin
        if (press[swhd_pkg::KEY_PROG]) begin
          state_next.mode = swhd_pkg::SWHD_MODE_MENU;
        end
      end
      swhd_pkg::SWHD_MODE_MENU: begin
        if (press[swhd_pkg::KEY_PROG]) begin
          state_next.mode = swhd_pkg::SWHD_MODE_RUN;
        end else if (press[swhd_pkg::KEY_UP]) begin
          state_next.menuSel = (state_reg.menuSel == swhd_pkg::MENU_LAST) ?
              swhd_pkg::MENU_FIRST : state_reg.menuSel + 3'h1;
        end else if (press[swhd_pkg::KEY_DOWN]) begin
          state_next.menuSel = (state_reg.menuSel == swhd_pkg::MENU_FIRST) ?
              swhd_pkg::MENU_LAST : state_reg.menuSel - 3'h1;
        end else if (press[swhd_pkg::KEY_FUNC]) begin
          // Check menu only in full scope
          if (state_reg.menuSel == swhd_pkg::MENU_IO_CHECK && menuScopeCode == swhd_pkg::MENU_SCOPE_FULL) begin
            state_next.mode = swhd_pkg::SWHD_MODE_LIST;
            state_next.itemSel = swhd_pkg::ITEM_CTRL;
          end
        end
      end
      swhd_pkg::SWHD_MODE_LIST: begin
        if (press[swhd_pkg::KEY_PROG]) begin
          state_next.mode = swhd_pkg::SWHD_MODE_RUN;
        end else if (press[swhd_pkg::KEY_RESET]) begin
          state_next.mode = swhd_pkg::SWHD_MODE_MENU;
        end else if (press[swhd_pkg::KEY_UP]) begin
          state_next.itemSel = (state_reg.itemSel == swhd_pkg::ITEM_METER) ?
              swhd_pkg::ITEM_CTRL : state_reg.itemSel + 3'h1;
        end else if (press[swhd_pkg::KEY_DOWN]) begin
          state_next.itemSel = (state_reg.itemSel == swhd_pkg::ITEM_CTRL) ?
              swhd_pkg::ITEM_METER : state_reg.itemSel - 3'h1;
        end else if (press[swhd_pkg::KEY_FUNC]) begin
          state_next.mode = swhd_pkg::SWHD_MODE_DATA;
          state_next.hexView = 1'b0;
        end
      end
      swhd_pkg::SWHD_MODE_DATA: begin
        if (press[swhd_pkg::KEY_PROG]) begin
          state_next.mode = swhd_pkg::SWHD_MODE_RUN;
        end else if (press[swhd_pkg::KEY_RESET]) begin
          state_next.mode = swhd_pkg::SWHD_MODE_LIST;
        end else if ((press[swhd_pkg::KEY_UP] || press[swhd_pkg::KEY_DOWN]) &&
                     state_reg.itemSel <= swhd_pkg::ITEM_COMM) begin
          state_next.hexView = !state_reg.hexView;
        end
      end
      default: begin
        state_next.mode = swhd_pkg::SWHD_MODE_RUN;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '{mode: swhd_pkg::SWHD_MODE_RUN, menuSel: swhd_pkg::MENU_RESET,
                     itemSel: swhd_pkg::ITEM_RESET, hexView: 1'b0, keySync1: '0,
                     keySync2: '0, keyPrev: '0, statusWord: swhd_pkg::STAT_RESET,
                     segments: '0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign statusWord = state_reg.statusWord;
  assign {ledDigit4, ledDigit3, ledDigit2, ledDigit1} = state_reg.segments;
  assign progMode = (state_reg.mode != swhd_pkg::SWHD_MODE_RUN);
  assign hexView = state_reg.hexView;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_busy_bit: assert property (@(posedge core_clk) disable iff (!rst_n)
    paramWriteBusy |=> statusWord[15] ##1 (statusWord[15] == $past(paramWriteBusy)))
    else $error("busy bit does not follow parameter write");
  a_link_bit: assert property (@(posedge core_clk) disable iff (!rst_n)
    !linkReady |=> !statusWord[12]) else $error("link bit set without link ready");
  a_fault_bit: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(faultFlag) |=> statusWord[11]) else $error("fault bit missed");
  a_limit_bits: assert property (@(posedge core_clk) disable iff (!rst_n)
    currentLimiting && !voltageLimiting |=> statusWord[8:7] == 2'b10) else $error("current limit bit wrong");
  a_volt_bit: assert property (@(posedge core_clk) disable iff (!rst_n)
    voltageLimiting |=> statusWord[7]) else $error("voltage limit bit missed");
  a_bus_bit: assert property (@(posedge core_clk) disable iff (!rst_n)
    !busAboveUndervoltage |=> !statusWord[5]) else $error("bus bit set below level");
  a_stage_bits: assert property (@(posedge core_clk) disable iff (!rst_n)
    outputShutOff && !dcBraking |=> statusWord[3:2] == 2'b10) else $error("shut off bit wrong");
  a_brake_bit: assert property (@(posedge core_clk) disable iff (!rst_n)
    dcBraking |=> statusWord[2]) else $error("braking bit missed");
  a_dir_bits: assert property (@(posedge core_clk) disable iff (!rst_n)
    backwardRun && !forwardRun |=> statusWord[1:0] == 2'b10) else $error("direction bits wrong");
  a_fwd_bit: assert property (@(posedge core_clk) disable iff (!rst_n)
    forwardRun && !backwardRun |=> statusWord[1:0] == 2'b01) else $error("forward bit wrong");
  a_zero_bits: assert property (@(posedge core_clk) disable iff (!rst_n)
    (statusWord & 16'h6050) == 16'h0000) else $error("reserved status bit set");
  a_ramp_bits: assert property (@(posedge core_clk) disable iff (!rst_n)
    slowingDown && !speedingUp |=> statusWord[10:9] == 2'b10) else $error("ramp bits wrong");
  a_left_digit: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_reg.mode == swhd_pkg::SWHD_MODE_RUN && statusWord[15:12] == 4'h8 |=> ledDigit4 == 8'h7f)
    else $error("leftmost digit not top nibble");
  a_glyph_b: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_reg.mode == swhd_pkg::SWHD_MODE_RUN && statusWord[3:0] == 4'hb |=> ledDigit1 == 8'h7c)
    else $error("glyph b wrong");
  a_menu_entry: assert property (@(posedge core_clk) disable iff (!rst_n)
    !progMode && $rose(keyProg) |-> ##[1:3] progMode) else $error("menu not entered");
  a_scope_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_reg.mode == swhd_pkg::SWHD_MODE_MENU && menuScopeCode != swhd_pkg::MENU_SCOPE_FULL
    |=> state_reg.mode != swhd_pkg::SWHD_MODE_LIST) else $error("check menu opened outside full scope");
  a_view_toggle: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_reg.mode == swhd_pkg::SWHD_MODE_DATA && state_reg.itemSel <= swhd_pkg::ITEM_COMM &&
    press[swhd_pkg::KEY_UP] && !press[swhd_pkg::KEY_PROG] && !press[swhd_pkg::KEY_RESET]
    |=> hexView != $past(hexView)) else $error("view not toggled");
  a_reset_back: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_reg.mode == swhd_pkg::SWHD_MODE_DATA && press[swhd_pkg::KEY_RESET] && !press[swhd_pkg::KEY_PROG]
    |=> state_reg.mode == swhd_pkg::SWHD_MODE_LIST) else $error("reset key did not return to list");
  a_volt_item: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_reg.mode == swhd_pkg::SWHD_MODE_DATA && state_reg.itemSel == swhd_pkg::ITEM_VOLT &&
    voltageInputValue[3:0] == 4'hd |=> ledDigit1 == 8'h5e) else $error("voltage item not shown");

endmodule : swhd_display

// file: bench/swhd_operator.sv
module swhd_operator (
  // Clock
  input wire logic core_clk,
  // Keypad and configuration
  output logic [4:0] keyPins,
  output logic [1:0] menuScopeCode
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Operator setup
  // ----------------------------------------------------------------
  // Full menu scope
  initial begin
    keyPins = 5'h00;
    menuScopeCode = swhd_pkg::MENU_SCOPE_FULL;
  end

  // Held well past the sync delay, released long enough to rearm
  task automatic press(input int k);
    @(negedge core_clk);
    keyPins[k] = 1'b1;
    repeat (4) @(negedge core_clk);
    keyPins[k] = 1'b0;
    repeat (6) @(negedge core_clk);
  endtask : press

  task automatic set_scope(input logic [1:0] code);
    @(negedge core_clk);
    menuScopeCode = code;
  endtask : set_scope
endmodule : swhd_operator

// file: bench/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0] GL [16] = '{8'h3f, 8'h06, 8'h5b, 8'h4f, 8'h66, 8'h6d, 8'h7d, 8'h07,
    8'h7f, 8'h6f, 8'h77, 8'h7c, 8'h39, 8'h5e, 8'h79, 8'h71};
  localparam int unsigned POS [12] = '{swhd_pkg::BIT_PARAM_WRITE, swhd_pkg::BIT_LINK_READY,
    swhd_pkg::BIT_FAULT_FLAG, swhd_pkg::BIT_SLOWING_DOWN, swhd_pkg::BIT_SPEEDING_UP,
    swhd_pkg::BIT_CURRENT_LIMITING, swhd_pkg::BIT_VOLTAGE_LIMITING, swhd_pkg::BIT_BUS_ABOVE_UV,
    swhd_pkg::BIT_OUTPUT_SHUT_OFF, swhd_pkg::BIT_DC_BRAKING, swhd_pkg::BIT_BACKWARD_RUN,
    swhd_pkg::BIT_FORWARD_RUN};

  logic core_clk, rst_n, progMode, hexView;
  logic [11:0] cond;
  logic [15:0] termIn, linkIn, termOut, voltIn, currIn, meterIn, statusWord;
  logic [4:0] keyPins;
  logic [1:0] menuScopeCode;
  logic [7:0] ledDigit4, ledDigit3, ledDigit2, ledDigit1;
  logic [31:0] shown;
  int miscompares = 0;
  int n_tests = 0;
  assign shown = {ledDigit4, ledDigit3, ledDigit2, ledDigit1};

  swhd_operator op (.core_clk(core_clk), .keyPins(keyPins), .menuScopeCode(menuScopeCode));

  swhd_display dut (.core_clk(core_clk), .rst_n(rst_n), .paramWriteBusy(cond[0]), .linkReady(cond[1]),
    .faultFlag(cond[2]), .slowingDown(cond[3]), .speedingUp(cond[4]), .currentLimiting(cond[5]),
    .voltageLimiting(cond[6]), .busAboveUndervoltage(cond[7]), .outputShutOff(cond[8]),
    .dcBraking(cond[9]), .backwardRun(cond[10]), .forwardRun(cond[11]), .menuScopeCode(menuScopeCode),
    .keyProg(keyPins[swhd_pkg::KEY_PROG]), .keyUp(keyPins[swhd_pkg::KEY_UP]),
    .keyDown(keyPins[swhd_pkg::KEY_DOWN]), .keyFunc(keyPins[swhd_pkg::KEY_FUNC]),
    .keyReset(keyPins[swhd_pkg::KEY_RESET]), .terminalInputs(termIn), .linkTerminalInputs(linkIn),
    .terminalOutputs(termOut), .voltageInputValue(voltIn), .currentInputValue(currIn),
    .meterOutputValue(meterIn), .statusWord(statusWord), .ledDigit4(ledDigit4), .ledDigit3(ledDigit3),
    .ledDigit2(ledDigit2), .ledDigit1(ledDigit1), .progMode(progMode), .hexView(hexView));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  function automatic logic [31:0] hexOf(input logic [15:0] w);
    return {GL[w[15:12]], GL[w[11:8]], GL[w[7:4]], GL[w[3:0]]};
  endfunction : hexOf

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(negedge core_clk);
  endtask : settle

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_status();
    for (int i = 0; i < 12; i++) begin
      cond = 12'h001 << i;
      settle(3);
      chk("statusWord", 32'(16'h0001 << POS[i]), {16'h0, statusWord});
      chk("running display", hexOf(16'h0001 << POS[i]), shown);
    end
    cond = 12'hd00;
    settle(3);
    chk("statusWord b", 32'h000b, {16'h0, statusWord});
    chk("display b", {GL[0], GL[0], GL[0], GL[11]}, shown);
    cond = 12'hfff;
    settle(3);
    chk("statusWord all", 32'h9faf, {16'h0, statusWord});
    chk("display all", {GL[9], GL[15], GL[10], GL[15]}, shown);
    cond = 12'h000;
    settle(3);
    $display("Test status word done");
  endtask : t_status

  task automatic t_menu();
    op.press(swhd_pkg::KEY_RESET);
    chk("reset key in running", 32'h0, {31'h0, progMode});
    op.press(swhd_pkg::KEY_PROG);
    chk("progMode", 32'h1, {31'h0, progMode});
    chk("menu 1", {24'h0, GL[1]}, shown);
    op.press(swhd_pkg::KEY_FUNC);
    chk("func in menu 1", {24'h0, GL[1]}, shown);
    repeat (3) op.press(swhd_pkg::KEY_UP);
    chk("menu 4", {24'h0, GL[4]}, shown);
    op.set_scope(2'h0);
    op.press(swhd_pkg::KEY_FUNC);
    chk("func outside full scope", {24'h0, GL[4]}, shown);
    op.set_scope(swhd_pkg::MENU_SCOPE_FULL);
    op.press(swhd_pkg::KEY_FUNC);
    chk("list 4_00", {GL[4], 8'h08, GL[0], GL[0]}, shown);
    $display("Test menu done");
  endtask : t_menu

  task automatic t_terminals();
    termIn = 16'h0005;
    termOut = 16'h0101;
    op.press(swhd_pkg::KEY_FUNC);
    chk("hexView on entry", 32'h0, {31'h0, hexView});
    chk("segment view", 32'h01010005, shown);
    op.press(swhd_pkg::KEY_UP);
    chk("hexView up", 32'h1, {31'h0, hexView});
    chk("hex view", hexOf(16'h0005), shown);
    op.press(swhd_pkg::KEY_DOWN);
    chk("hexView down", 32'h0, {31'h0, hexView});
    termIn = 16'h0000;
    termOut = 16'h0000;
    settle(3);
    chk("all off", 32'h40404040, shown);
    op.press(swhd_pkg::KEY_RESET);
    chk("back to list", {GL[4], 8'h08, GL[0], GL[0]}, shown);
    op.press(swhd_pkg::KEY_UP);
    chk("list 4_01", {GL[4], 8'h08, GL[0], GL[1]}, shown);
    linkIn = 16'he003;
    op.press(swhd_pkg::KEY_FUNC);
    chk("link segment view", 32'h0000e003, shown);
    op.press(swhd_pkg::KEY_RESET);
    $display("Test terminals done");
  endtask : t_terminals

  task automatic t_analog();
    logic [15:0] v [4] = '{16'h0123, 16'h4567, 16'h89ab, 16'hcfed};
    op.press(swhd_pkg::KEY_UP);
    op.press(swhd_pkg::KEY_FUNC);
    foreach (v[i]) begin
      voltIn = v[i];
      settle(3);
      chk("voltage view", hexOf(v[i]), shown);
    end
    op.press(swhd_pkg::KEY_UP);
    chk("up ignored on item 2", hexOf(16'hcfed), shown);
    currIn = 16'h2040;
    meterIn = 16'h0987;
    op.press(swhd_pkg::KEY_RESET);
    op.press(swhd_pkg::KEY_UP);
    op.press(swhd_pkg::KEY_FUNC);
    chk("current view", hexOf(16'h2040), shown);
    op.press(swhd_pkg::KEY_RESET);
    op.press(swhd_pkg::KEY_UP);
    op.press(swhd_pkg::KEY_FUNC);
    chk("meter view", hexOf(16'h0987), shown);
    op.press(swhd_pkg::KEY_RESET);
    op.press(swhd_pkg::KEY_RESET);
    chk("back to menu", {24'h0, GL[4]}, shown);
    op.press(swhd_pkg::KEY_PROG);
    chk("running again", 32'h0, {31'h0, progMode});
    chk("running display", hexOf(16'h0000), shown);
    $display("Test analog items done");
  endtask : t_analog

  // Generous bound: the whole sequence needs a few hundred cycles
  initial begin
    #300000;
    miscompares++;
    final_report();
  end

  initial begin
    rst_n = 1'b0;
    cond = 12'h000;
    termIn = 16'h0000;
    linkIn = 16'h0000;
    termOut = 16'h0000;
    voltIn = 16'h0000;
    currIn = 16'h0000;
    meterIn = 16'h0000;
    settle(4);
    chk("reset outputs", 32'h0, {statusWord, 14'h0, progMode, hexView});
    chk("reset display", 32'h0, shown);
    rst_n = 1'b1;
    t_status();
    t_menu();
    t_terminals();
    t_analog();
    final_report();
  end
endmodule : testbench
